// ---- bench/mpp_gate_drv.sv ----
// Behavioural gate drivers and inductors for three channels
// Assumes gate commands registered on aclk
`timescale 1ns/1ps
module mpp_gate_drv (
   input  wire       aclk,
   input  wire [2:0] upper_gate_cmd,
   input  wire [2:0] lower_gate_cmd,
   output reg  [2:0] zero_current
);
   reg [3:0] cur [0:2]; // Inductor current, never negative
   integer   i;
   initial for (i = 0; i < 3; i = i + 1) cur[i] = 4'h0;
   // Upper on ramps up; lower or body diode ramps down to zero
   always @(posedge aclk) begin
      for (i = 0; i < 3; i = i + 1) begin
         if (upper_gate_cmd[i] && cur[i] != 4'hf)
            cur[i] <= cur[i] + 4'h1;
         else if (!upper_gate_cmd[i] && cur[i] != 4'h0)
            cur[i] <= cur[i] - 4'h1;
      end
   end
   // Zero flag seen by the emulation logic
   always @* begin
      for (i = 0; i < 3; i = i + 1) zero_current[i] = (cur[i] == 4'h0);
   end
endmodule

// ---- bench/mpp_top_assertions.sv ----
// Checker for gate commands and power state of mpp_top
// Bound to mpp_top below; sees only its ports
`timescale 1ns/1ps
module mpp_chk (
   input wire       aclk,
   input wire       aresetn,
   input wire       ce,
   input wire       phase_align_trip,
   input wire       phase3_sense_neg,
   input wire       cpu_reset_hold_n,
   input wire       soft_start_busy,
   input wire [2:0] zero_current,
   input wire [2:0] upper_gate_cmd,
   input wire [2:0] lower_gate_cmd,
   input wire       lower_gate_drive_reduction,
   input wire       diode_emulation,
   input wire       continuous_conduction,
   input wire [2:0] interval_start
);
   reg [1:0] rises;   // Channel one rises this interval
   reg       tripped; // Trip seen; the one-rise limit is lifted
   // Count rises per interval; saturates so it never wraps back to legal
   always @(posedge aclk) begin
      if (!aresetn || interval_start[0]) begin
         // A rise on the opening edge belongs to the new interval
         rises <= (aresetn && $rose(upper_gate_cmd[0])) ? 2'h1 : 2'h0;
         tripped <= aresetn && phase_align_trip;
      end else begin
         if ($rose(upper_gate_cmd[0]) && rises != 2'h3)
            rises <= rises + 2'h1;
         if (phase_align_trip)
            tripped <= 1'b1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_gate_excl: assert property (!(|(upper_gate_cmd & lower_gate_cmd)))
      else $error("upper and lower gate on together");
   a_lower_follows: assert property ($past(aresetn) && $past(aresetn, 2)
      && continuous_conduction && $past(continuous_conduction)
      && !upper_gate_cmd[0] |-> lower_gate_cmd[0])
      else $error("lower gate off while pwm low");
   a_one_rise: assert property (rises <= 2'h1 || tripped)
      else $error("second rise in one interval");
   a_trip_on: assert property (phase_align_trip && ce |=> upper_gate_cmd[0])
      else $error("trip did not force gate on");
   a_two_phase: assert property (phase3_sense_neg[*3]
      |-> !upper_gate_cmd[2] && !lower_gate_cmd[2])
      else $error("channel three active in two phase");
   a_mode_pair: assert property ((lower_gate_drive_reduction == diode_emulation)
      && !(diode_emulation && continuous_conduction))
      else $error("mode outputs disagree");
   a_dem_single: assert property (diode_emulation && $past(diode_emulation)
      |-> upper_gate_cmd[2:1] == 2'h0 && lower_gate_cmd[2:1] == 2'h0)
      else $error("dropped channel still driven");
   a_start_normal: assert property (soft_start_busy[*3] |-> !diode_emulation)
      else $error("low power during soft start");
   a_hold_normal: assert property ((!cpu_reset_hold_n)[*3] |-> !diode_emulation)
      else $error("low power while cpu reset held");
   a_zero_off: assert property (diode_emulation && $past(diode_emulation)
      && zero_current[0] && !upper_gate_cmd[0] |=> !lower_gate_cmd[0])
      else $error("lower gate on at zero current");
   a_start_pulse: assert property (interval_start[0] |=> !interval_start[0])
      else $error("interval start longer than one cycle");
   c_dem: cover property (diode_emulation && upper_gate_cmd[0]);
   c_trip: cover property (phase_align_trip ##1 upper_gate_cmd == 3'h7);
   c_three: cover property ($rose(upper_gate_cmd[2]));
endmodule

bind mpp_top mpp_chk u_chk (.aclk, .aresetn, .ce, .phase_align_trip,
   .phase3_sense_neg, .cpu_reset_hold_n, .soft_start_busy, .zero_current,
   .upper_gate_cmd, .lower_gate_cmd, .lower_gate_drive_reduction,
   .diode_emulation, .continuous_conduction, .interval_start);

// ---- bench/mpp_top_tb.sv ----
// Self-checking bench for mpp_top with random comparator stimulus
// Assumes mpp_defines.vh on the include path
`timescale 1ns/1ps
`include "mpp_defines.vh"
module mpp_top_tb;
   reg aclk, aresetn, ce, freq_set_pin, phase_align_trip, phase3_sense_neg;
   reg power_state_request_n, cpu_reset_hold_n, soft_start_busy;
   reg ref_move_busy, ref_move_ok, rnd;
   reg [2:0] corrected_error_level;
   reg [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   reg [31:0] s_axi_wdata, rd;
   reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire [2:0] zero_current, upper_gate_cmd, lower_gate_cmd, interval_start;
   wire lower_gate_drive_reduction, diode_emulation, continuous_conduction;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   reg [1:0] rs;
   integer num_errors, check_count, seed, n, d, s;
   mpp_top #(.HOLD_CYC(20)) u_dut (.aclk, .aresetn, .ce, .freq_set_pin,
      .corrected_error_level, .phase_align_trip, .phase3_sense_neg,
      .power_state_request_n, .cpu_reset_hold_n, .soft_start_busy,
      .ref_move_busy, .ref_move_ok, .zero_current, .upper_gate_cmd,
      .lower_gate_cmd, .lower_gate_drive_reduction, .diode_emulation,
      .continuous_conduction, .interval_start, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   mpp_gate_drv u_drv (.aclk, .upper_gate_cmd, .lower_gate_cmd, .zero_current);
   always #20 aclk = ~aclk;
   // Random comparator results and rare trips
   always @(posedge aclk) begin
      if (rnd) begin
         corrected_error_level <= $random(seed);
         phase_align_trip <= (($random(seed) & 63) == 0);
      end
   end
   task end_of_test;
      begin
         if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp, input [8*10:1] nm);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // A spent bound ends the run at once
   task bound(input integer cnt, input integer lim);
      if (cnt >= lim) begin
         chk(cnt, 0, "wait");
         end_of_test;
      end
   endtask
   function in_span(input integer v, input integer lo, input integer hi);
      in_span = (v >= lo) && (v <= hi);
   endfunction
   // Write: address and data offered together, each dropped when taken
   task wr(input [3:0] a, input [31:0] dt, input [1:0] er);
      reg aw, w, b;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= dt;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         b = 0;
         n = 0;
         while (!b && n < 100) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            rs = s_axi_bresp;
            n = n + 1;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
         end
         bound(n, 100);
         chk(rs, er, "bresp");
      end
   endtask
   task rdc(input [3:0] a, input [31:0] ex, input [1:0] er);
      reg ar, r;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         r = 0;
         n = 0;
         while (!r && n < 100) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid && s_axi_rready;
            {rs, rd} = {s_axi_rresp, s_axi_rdata};
            n = n + 1;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
         end
         bound(n, 100);
         chk(rs, er, "rresp");
         if (er == `MPP_RESP_OKAY) chk(rd, ex, "rdata");
      end
   endtask
   task wait_is(input integer k, output integer c);
      begin
         c = 0;
         do begin
            @(negedge aclk);
            c = c + 1;
         end while (interval_start[k] !== 1'b1 && c < 200);
         bound(c, 200);
      end
   endtask
   task mode(input [2:0] ex, input integer lim);
      begin
         n = 0;
         while ({diode_emulation, continuous_conduction,
                 lower_gate_drive_reduction} !== ex && n < lim) begin
            @(negedge aclk);
            n = n + 1;
         end
         chk({diode_emulation, continuous_conduction,
              lower_gate_drive_reduction}, ex, "mode");
         @(posedge aclk);
      end
   endtask
   initial begin
      {aclk, aresetn, freq_set_pin, phase_align_trip, phase3_sense_neg} = 0;
      {soft_start_busy, ref_move_busy, rnd, corrected_error_level} = 0;
      {ce, power_state_request_n, cpu_reset_hold_n, ref_move_ok} = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
      {s_axi_wdata, s_axi_wstrb} = {32'h0000_0000, 4'hf};
      {num_errors, check_count, seed} = {32'd0, 32'd0, 32'd64546};
      repeat (9) @(posedge aclk);
      @(negedge aclk);
      chk({upper_gate_cmd, lower_gate_cmd, continuous_conduction}, 7'h01, "rst");
      @(posedge aclk);
      aresetn <= 1'b1;
      soft_start_busy <= 1'b1;
      rdc(`MPP_REG_CTRL, 32'h0000_0003, `MPP_RESP_OKAY);
      rdc(`MPP_REG_PERIOD, 32'h0000_0019, `MPP_RESP_OKAY);
      rdc(4'hc, 32'h0000_0000, `MPP_RESP_SLVERR);
      wr(4'hc, 32'h0000_0001, `MPP_RESP_SLVERR);
      wr(`MPP_REG_PERIOD, 32'h0000_0030, `MPP_RESP_OKAY);
      rdc(`MPP_REG_PERIOD, 32'h0000_0030, `MPP_RESP_OKAY);
      soft_start_busy <= 1'b0;
      rnd <= 1'b1;
      wait_is(0, n);
      wait_is(1, d);
      wait_is(0, s);
      chk(in_span(3 * d, d + s - 2, d + s + 2), 1, "phase");
      chk(in_span(d + s, 48, 49), 1, "period");
      wait_is(2, d);
      chk(d, 32, "ph3");
      repeat (10) @(posedge aclk);
      freq_set_pin <= 1'b1;
      wait_is(0, n);
      chk(n < 4, 1, "restart");
      @(posedge aclk);
      freq_set_pin <= 1'b0;
      phase3_sense_neg <= 1'b1;
      repeat (200) @(posedge aclk);
      @(negedge aclk);
      chk({upper_gate_cmd[2], lower_gate_cmd[2]}, 0, "ch3");
      @(posedge aclk);
      phase3_sense_neg <= 1'b0;
      power_state_request_n <= 1'b0;
      mode(3'b101, 50);
      rdc(`MPP_REG_STATUS, 32'h0000_0017, `MPP_RESP_OKAY);
      repeat (200) @(posedge aclk);
      power_state_request_n <= 1'b1;
      mode(3'b010, 3);
      wr(`MPP_REG_CTRL, 32'h0000_0001, `MPP_RESP_OKAY);
      power_state_request_n <= 1'b0;
      repeat (30) @(posedge aclk);
      mode(3'b010, 0);
      @(negedge aclk);
      chk({upper_gate_cmd[2:1], lower_gate_cmd[2:1]}, 0, "drop");
      @(posedge aclk);
      power_state_request_n <= 1'b1;
      wr(`MPP_REG_CTRL, 32'h0000_0003, `MPP_RESP_OKAY);
      soft_start_busy <= 1'b1;
      power_state_request_n <= 1'b0;
      repeat (30) @(posedge aclk);
      mode(3'b010, 0);
      soft_start_busy <= 1'b0;
      mode(3'b101, 50);
      {ref_move_ok, ref_move_busy} <= 2'b01;
      repeat (5) @(posedge aclk);
      ref_move_busy <= 1'b0;
      repeat (30) @(posedge aclk);
      mode(3'b010, 0);
      {ref_move_ok, ref_move_busy} <= 2'b11;
      repeat (5) @(posedge aclk);
      ref_move_busy <= 1'b0;
      mode(3'b101, 50);
      cpu_reset_hold_n <= 1'b0;
      repeat (10) @(posedge aclk);
      mode(3'b010, 0);
      cpu_reset_hold_n <= 1'b1;
      repeat (12) @(posedge aclk);
      mode(3'b010, 0);
      mode(3'b101, 40);
      end_of_test;
   end
endmodule

// ---- rtl/mpp_defines.vh ----
// Constants for the multiphase PWM and power state block
// Assumes a 25 MHz aclk and an AXI4-Lite master with 32-bit data
`ifndef MPP_DEFINES_VH
`define MPP_DEFINES_VH

// Register byte offsets
`define MPP_REG_CTRL     4'h0
`define MPP_REG_PERIOD   4'h4
`define MPP_REG_STATUS   4'h8

// Control register fields
`define MPP_CTRL_RUN     0
`define MPP_CTRL_FULL    1

// Status register fields
`define MPP_ST_LOWPWR    0
`define MPP_ST_DEM       1
`define MPP_ST_GDR       2
`define MPP_ST_TWO       3
`define MPP_ST_ARMED     4

// Reset values
`define MPP_CTRL_RST     2'h3
`define MPP_PERIOD_RST   16'h0019

// AXI responses
`define MPP_RESP_OKAY    2'h0
`define MPP_RESP_SLVERR  2'h2

// Timing: 50 ms holdoff after cpu reset release at 40 ns
`define MPP_HOLD_MS      50
`define MPP_CLK_NS       40
`define MPP_HOLD_CYC     ((`MPP_HOLD_MS * 1000000) / `MPP_CLK_NS)

`endif

// ---- rtl/mpp_top.v ----
// Interval timing, gate commands and power state control
// Assumes synchronous inputs on aclk and an AXI4-Lite master
`timescale 1ns/1ps
`include "mpp_defines.vh"

module mpp_top #(
   parameter HOLD_CYC = `MPP_HOLD_CYC, // Holdoff cycles after cpu reset
   parameter PW       = 16             // Period counter width
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   // Interval source from the frequency set pin
   input  wire        freq_set_pin,
   // Per-channel comparator, corrected error above ramp
   input  wire [2:0]  corrected_error_level,
   input  wire        phase_align_trip,
   input  wire        phase3_sense_neg,
   input  wire        power_state_request_n,
   input  wire        cpu_reset_hold_n,
   input  wire        soft_start_busy,
   input  wire        ref_move_busy,
   input  wire        ref_move_ok,
   input  wire [2:0]  zero_current,
   output reg  [2:0]  upper_gate_cmd,
   output reg  [2:0]  lower_gate_cmd,
   output reg         lower_gate_drive_reduction,
   output reg         diode_emulation,
   output reg         continuous_conduction,
   output reg  [2:0]  interval_start,
   // AXI4-Lite slave
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // Software state
   reg  [1:0]    ctrl;          // Run enable, full variant select
   reg  [PW-1:0] period;        // Cycles per switching period
   // Write channel capture
   reg           aw_held;       // Address taken, waiting on data
   reg           w_held;        // Data taken, waiting on address
   reg  [3:0]    aw_addr;       // Captured write address
   reg  [31:0]   w_data;        // Captured write data
   reg  [3:0]    w_strb;        // Captured byte enables
   // Interval timing
   reg  [PW-1:0] phase_cnt;     // Position within the period
   reg           fs_prev;       // Last freq_set_pin sample
   reg  [2:0]    rose;          // Rising edge spent this interval
   reg  [2:0]    pwm;           // Internal PWM per channel
   reg  [2:0]    dead;          // Latched zero-current cutoff
   // Power state
   reg           low_power;     // Honoured low power state
   reg           armed;         // Allowed to honour request
   reg  [31:0]   hold_cnt;      // Holdoff counter
   reg           cpu_prev;      // Last cpu reset sample
   reg           ref_prev;      // Last reference move busy sample
   reg           ref_fail;      // Last reference move failed
   // A failed move must not re-arm on its own; only a good
   // completion clears this, so the low state stays refused
   // until then, except that a cpu reset holdoff still re-arms

   wire          two_phase = phase3_sense_neg;
   wire          running   = ctrl[`MPP_CTRL_RUN];
   wire          full_var  = ctrl[`MPP_CTRL_FULL];
   // Period tick from the pin rise or the internal counter
   wire          fs_rise   = freq_set_pin & ~fs_prev;
   // Compare by >= so a period shrunk below the count wraps at once
   // instead of running through the whole counter range
   wire          wrap      = (phase_cnt >= period - 1'b1);
   wire          tick      = fs_rise | wrap;
   wire [PW-1:0] third     = period / 2'd3;
   wire [PW-1:0] two_third = third + third;
   wire [PW-1:0] half      = {1'b0, period[PW-1:1]};
   reg  [2:0]    starts;    // Interval start per channel
   reg  [2:0]    active;    // Channels allowed to fire
   reg  [2:0]    next_pwm;  // PWM after this edge
   integer       i;         // Loop index, combinational only
   integer       j;         // Loop index, clocked only

   // Byte-lane merge shared by both writable registers
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0]  strb;
      integer      k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = dat[k*8 +: 8];
            end
         end
      end
   endfunction

   // Merged write words; only the low bits reach each register,
   // so upper lanes of a wide write are dropped on purpose
   wire [31:0]   ctrl_wr   = merge({30'h0000_0000, ctrl}, w_data, w_strb);
   wire [31:0]   period_wr = merge({{(32-PW){1'b0}}, period}, w_data,
                                   w_strb);

   // Staggered interval starts and the active channel set
   always @* begin
      starts = 3'h0;
      active = 3'h0;
      // Channel one opens on the wrap edge, when the count goes to
      // zero; the others open on the edge that brings the count to
      // their offset, hence the minus one, so spacing is exact
      starts[0] = tick;
      if (two_phase) begin
         starts[1] = (phase_cnt == half - 1'b1);
      end else begin
         starts[1] = (phase_cnt == third - 1'b1);
         starts[2] = (phase_cnt == two_third - 1'b1);
      end
      if (running) begin
         active = two_phase ? 3'h3 : 3'h7;
         if (low_power) begin
            active = 3'h1;
         end
      end
   end

   // Comparator to PWM, with one rise per interval and trip override
   // Trip outranks the comparator but never wakes a disabled channel
   always @* begin
      next_pwm = 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
         if (!active[i]) begin
            next_pwm[i] = 1'b0;
         end else if (phase_align_trip) begin
            next_pwm[i] = 1'b1;
         end else if (!corrected_error_level[i]) begin
            next_pwm[i] = 1'b0;
         end else if (pwm[i]) begin
            next_pwm[i] = 1'b1;
         end else begin
            // A spent rise stays blocked unless a new interval opens
            next_pwm[i] = !rose[i] || starts[i];
         end
      end
   end

   // Interval counter, PWM state and gate outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         phase_cnt      <= {PW{1'b0}};
         fs_prev        <= 1'b0;
         rose           <= 3'h0;
         pwm            <= 3'h0;
         dead           <= 3'h0;
         upper_gate_cmd <= 3'h0;
         lower_gate_cmd <= 3'h0;
         interval_start <= 3'h0;
      end else if (ce) begin
         fs_prev        <= freq_set_pin;
         phase_cnt      <= tick ? {PW{1'b0}} : phase_cnt + 1'b1;
         interval_start <= starts;
         pwm            <= next_pwm;
         // Gates are the registered next PWM, one cycle behind inputs
         for (j = 0; j < 3; j = j + 1) begin
            // Rise bookkeeping restarts with each channel interval
            if (next_pwm[j] && !pwm[j]) begin
               rose[j] <= 1'b1;
            end else if (starts[j]) begin
               rose[j] <= 1'b0;
            end
            // Zero current latches until the upper switch fires or an interval starts;
            // a zero seen on an interval start still wins, so the
            // lower switch cannot pull current negative there
            if (next_pwm[j]) begin
               dead[j] <= 1'b0;
            end else if (diode_emulation && zero_current[j]) begin
               dead[j] <= 1'b1;
            end else if (starts[j]) begin
               dead[j] <= 1'b0;
            end
            upper_gate_cmd[j] <= next_pwm[j];
            lower_gate_cmd[j] <= active[j] && !next_pwm[j] &&
                                 !(diode_emulation &&
                                   (dead[j] || zero_current[j]));
         end
      end
   end

   // Power state arbitration with soft-start and cpu reset holds
   always @(posedge aclk) begin
      if (!aresetn) begin
         low_power                  <= 1'b0;
         armed                      <= 1'b0;
         hold_cnt                   <= 32'h0000_0000;
         // Idle level of the cpu hold pin, so reset starts no holdoff
         cpu_prev                   <= 1'b1;
         ref_prev                   <= 1'b0;
         ref_fail                   <= 1'b0;
         diode_emulation            <= 1'b0;
         continuous_conduction      <= 1'b1;
         lower_gate_drive_reduction <= 1'b0;
      end else if (ce) begin
         cpu_prev <= cpu_reset_hold_n;
         ref_prev <= ref_move_busy;
         if (soft_start_busy || ref_move_busy || !cpu_reset_hold_n) begin
            armed    <= 1'b0;
            hold_cnt <= 32'h0000_0000;
         // Holdoff counts from the release edge; a new hold restarts it
         end else if (cpu_reset_hold_n && !cpu_prev) begin
            hold_cnt <= HOLD_CYC;
         end else if (hold_cnt != 32'h0000_0000) begin
            hold_cnt <= hold_cnt - 1'b1;
            armed    <= (hold_cnt == 32'h0000_0001);
         end else if (ref_prev && !ref_move_busy) begin
            // A failed reference move keeps the normal state
            armed    <= ref_move_ok;
            ref_fail <= !ref_move_ok;
         end else if (!armed && !ref_prev && !ref_fail) begin
            // End of soft-start or of a clean move re-arms
            armed <= 1'b1;
         end
         // Every mode output decodes the same term, so they switch
         // together on one edge and never disagree for a cycle
         // Low input honoured only when armed; high restores at once
         low_power <= armed && !power_state_request_n &&
                      !soft_start_busy && !ref_move_busy &&
                      cpu_reset_hold_n;
         diode_emulation <= armed && !power_state_request_n &&
                            !soft_start_busy && !ref_move_busy &&
                            cpu_reset_hold_n && full_var;
         continuous_conduction <= !(armed && !power_state_request_n &&
                                    !soft_start_busy && !ref_move_busy &&
                                    cpu_reset_hold_n && full_var);
         lower_gate_drive_reduction <= armed && !power_state_request_n &&
                                       !soft_start_busy && !ref_move_busy &&
                                       cpu_reset_hold_n && full_var;
      end
   end

   // AXI4-Lite write: address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `MPP_RESP_OKAY;
         ctrl          <= `MPP_CTRL_RST;
         period        <= `MPP_PERIOD_RST;
      end else if (ce) begin
         // Readys pulse for one cycle, so a held request is taken once
         // and the next one waits for the response to clear
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         // Commit once both halves are in, then answer
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `MPP_RESP_OKAY;
            case (aw_addr)
               `MPP_REG_CTRL: begin
                  ctrl <= ctrl_wr[1:0];
               end
               `MPP_REG_PERIOD: begin
                  period <= period_wr[PW-1:0];
               end
               `MPP_REG_STATUS: begin
                  // Read-only: write ignored
               end
               default: begin
                  s_axi_bresp <= `MPP_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read: one-cycle answer after address taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `MPP_RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `MPP_RESP_OKAY;
            case (s_axi_araddr)
               `MPP_REG_CTRL:   s_axi_rdata <= {30'h0000_0000, ctrl};
               `MPP_REG_PERIOD: s_axi_rdata <= {{(32-PW){1'b0}}, period};
               // Status bits are snapshots; a read never clears them
               `MPP_REG_STATUS: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rdata[`MPP_ST_LOWPWR] <= low_power;
                  s_axi_rdata[`MPP_ST_DEM]    <= diode_emulation;
                  s_axi_rdata[`MPP_ST_GDR]    <= lower_gate_drive_reduction;
                  s_axi_rdata[`MPP_ST_TWO]    <= two_phase;
                  s_axi_rdata[`MPP_ST_ARMED]  <= armed;
               end
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `MPP_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
